// >>> verilog/cse_event_ctrl.sv
// card status-change event controller for one 16-bit PC Card socket,
// with an APB register slave and routed interrupt outputs.
// assumes socket pins are asynchronous to pclk and the APB master runs
// on pclk.
//
// Function
// - masked source reads zero in status
// - unmasked active source sets flag, interrupts
// - clear on read or write-one, mode-selected
// - status bits seven to four read zero
// - either card-detect pin change sets flag
// - memory card ready rise sets flag
// - io card holds ready, warning flags zero
// - memory card battery warning sets flag
// - memory card battery dead sets bit zero
// - ring mode: bit zero set while ring line low
// - route field: none, smi, or irq n
// - route zero plus diag bit: pci
// - route zero, diag clear: pci if bit
// - detect mask gates detect interrupts
// - ready mask gates ready interrupts
// - warning mask gates, resets disabled
// - dead mask gates dead or status line
// - status reads zero after reset
// - card kind: zero memory, one io
// - ring enable switches shared line, default zero
// - pci route bit overrides route field
`timescale 1ns/1ps

module cse_event_ctrl
	import cse_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int IRQ_N  = 16
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	// socket
	input  wire cse_pins_s         socket_pins,
	// interrupt delivery
	output logic      [IRQ_N-1:0]  legacy_irq,
	output logic                   smi_request,
	output logic                   pci_int_request
);

	// ==========================================================
	// registers
	// ==========================================================
	logic [7:0]        gen_ctrl_q;
	logic [7:0]        route_mask_q;
	logic [7:0]        global_q;
	logic [7:0]        diag_q;
	logic [FLAG_W-1:0] flags_q;
	logic [FLAG_W-1:0] flags_d;
	logic              pready_q;
	logic [31:0]       prdata_q;
	logic              pslverr_q;
	logic [IRQ_N-1:0]  legacy_irq_q;
	logic              smi_q;
	logic              pci_q;

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic [PIN_W-1:0] sync3_q;
	logic [PIN_W-1:0] filt_q;
	logic [PIN_W-1:0] filt_d;
	logic [PIN_W-1:0] agree;
	logic [1:0]       fill_q;
	logic             primed_q;

	// a change counts only once the second and third stages agree
	assign agree  = ~(sync2_q ^ sync3_q);
	assign filt_d = (agree & sync3_q) | (~agree & filt_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			filt_q  <= '0;
		end else begin
			sync1_q <= socket_pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
		end
	end

	// no events until the chain holds real pin levels, else the reset
	// zeros would look like edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_q   <= '0;
			primed_q <= 1'b0;
		end else begin
			if (fill_q != SYNC_FILL) begin
				fill_q <= fill_q + 2'h1;
			end
			primed_q <= (fill_q == SYNC_FILL);
		end
	end

	// ==========================================================
	// edge detection on filtered pins
	// ==========================================================
	cse_pins_s now_p;
	cse_pins_s old_p;
	assign now_p = cse_pins_s'(filt_d);
	assign old_p = cse_pins_s'(filt_q);

	wire io_card  = gen_ctrl_q[BIT_CARD_KIND];
	wire ring_on  = gen_ctrl_q[BIT_RING_EN];
	wire wc_mode  = global_q[BIT_CLEAR_MODE];

	wire ev_detect = primed_q &
		((now_p.detect_pin_one ^ old_p.detect_pin_one) |
		 (now_p.detect_pin_two ^ old_p.detect_pin_two));
	wire ev_ready  = primed_q & now_p.card_ready & ~old_p.card_ready;
	wire ev_warn   = primed_q & ~now_p.battery_warn_line_n &
		old_p.battery_warn_line_n;
	// shared line: battery dead, status change or ring by mode
	wire ev_shared = primed_q & ~now_p.battery_or_ring_line_n &
		old_p.battery_or_ring_line_n;
	wire ring_lvl  = primed_q & ~old_p.battery_or_ring_line_n;

	// ==========================================================
	// flag set and clear
	// ==========================================================
	logic [FLAG_W-1:0] mask;
	logic [FLAG_W-1:0] kind_keep;
	logic [FLAG_W-1:0] set_v;
	logic [FLAG_W-1:0] clr_v;
	logic [FLAG_W-1:0] flags_vis;

	assign mask = route_mask_q[FLAG_W-1:0];

	// io cards never report ready or battery warning
	assign kind_keep = {1'b1, ~io_card, ~io_card, 1'b1};

	assign set_v[BIT_DETECT]   = ev_detect & mask[BIT_DETECT];
	assign set_v[BIT_READY]    = ev_ready & mask[BIT_READY];
	assign set_v[BIT_BAT_LOW]  = ev_warn & mask[BIT_BAT_LOW];
	assign set_v[BIT_BAT_DEAD] = mask[BIT_BAT_DEAD] &
		(ev_shared | (ring_on & ring_lvl));

	// what software sees: masked or kind-suppressed bits read zero
	assign flags_vis = flags_q & mask & kind_keep;

	// ==========================================================
	// apb decode
	// ==========================================================
	wire xfer_done = psel & penable & pready_q;
	wire rd_done   = xfer_done & ~pwrite;
	wire wr_done   = xfer_done & pwrite;
	wire lane0     = pstrb[0];

	wire hit_gen    = paddr[9:0] == reg_addr(IDX_GEN_CTRL);
	wire hit_status = paddr[9:0] == reg_addr(IDX_STATUS);
	wire hit_route  = paddr[9:0] == reg_addr(IDX_ROUTE_MASK);
	wire hit_global = paddr[9:0] == reg_addr(IDX_GLOBAL);
	wire hit_diag   = paddr[9:0] == reg_addr(IDX_DIAG);
	wire hi_zero    = (paddr >> 10) == '0;
	wire hit_any    = hi_zero &
		(hit_gen | hit_status | hit_route | hit_global | hit_diag);

	// clear-on-read drops only what the read returned, so an event
	// landing during the access is not lost
	assign clr_v = (rd_done & hit_status & ~wc_mode) ? prdata_q[FLAG_W-1:0] :
		(wr_done & hit_status & hi_zero & lane0 & wc_mode) ?
		pwdata[FLAG_W-1:0] : '0;

	// set wins over a clear landing in the same cycle
	// io cards hold ready and warning at zero, nothing latches hidden
	assign flags_d = ((flags_q & ~clr_v) | set_v) & kind_keep;

	logic [7:0] rd_byte;
	assign rd_byte =
		hit_gen    ? gen_ctrl_q :
		hit_status ? {{(8-FLAG_W){1'b0}}, flags_vis} :
		hit_route  ? route_mask_q :
		hit_global ? global_q :
		hit_diag   ? diag_q : 8'h00;

	// ==========================================================
	// apb slave: one wait state, answer registered
	// ==========================================================
	wire access = psel & penable & ~pready_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= RD_ZERO;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= access;
			pslverr_q <= access & ~hit_any;
			prdata_q  <= (access & ~pwrite & hit_any) ?
				{24'h00_0000, rd_byte} : RD_ZERO;
		end
	end

	wire wr_ok = wr_done & hi_zero & lane0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_ctrl_q   <= RST_GEN_CTRL;
			route_mask_q <= RST_ROUTE_MASK;
			global_q     <= RST_GLOBAL;
			diag_q       <= RST_DIAG;
		end else begin
			if (wr_ok & hit_gen) begin
				gen_ctrl_q <= pwdata[7:0];
			end
			if (wr_ok & hit_route) begin
				route_mask_q <= pwdata[7:0];
			end
			if (wr_ok & hit_global) begin
				global_q <= pwdata[7:0];
			end
			if (wr_ok & hit_diag) begin
				diag_q <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= RST_STATUS[FLAG_W-1:0];
		end else begin
			flags_q <= flags_d;
		end
	end

	// ==========================================================
	// interrupt routing
	// ==========================================================
	logic [ROUTE_W-1:0] route;
	assign route = route_mask_q[ROUTE_LSB +: ROUTE_W];

	wire pending = |flags_vis;
	wire pci_bit = gen_ctrl_q[BIT_PCI_ROUTE];
	wire diag_ev = diag_q[BIT_DIAG_EVENT];

	// pci path: override bit, or no legacy route with diag or pci bit
	wire to_pci = pci_bit |
		((route == ROUTE_NONE) & diag_ev);
	wire to_smi = ~to_pci & (route == ROUTE_SMI);
	wire to_irq = ~to_pci & (route != ROUTE_NONE) &
		(route != ROUTE_SMI);

	logic [IRQ_N-1:0] irq_d;
	always_comb begin
		irq_d = '0;
		if (to_irq & pending) begin
			irq_d[route] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			legacy_irq_q <= '0;
			smi_q        <= 1'b0;
			pci_q        <= 1'b0;
		end else begin
			legacy_irq_q <= irq_d;
			smi_q        <= to_smi & pending;
			pci_q        <= to_pci & pending;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign pready          = pready_q;
	assign prdata          = prdata_q;
	assign pslverr         = pslverr_q;
	assign legacy_irq      = legacy_irq_q;
	assign smi_request     = smi_q;
	assign pci_int_request = pci_q;

endmodule // cse_event_ctrl

// >>> include/cse_pkg.sv
// card status-change event package: register indices, field positions,
// reset values and the socket pin carrier.
// assumes a 32-bit APB master; registers sit at byte address index * 4.
package cse_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	// ==========================================================
	localparam logic [7:0] IDX_GEN_CTRL   = 8'h03;
	localparam logic [7:0] IDX_STATUS     = 8'h04;
	localparam logic [7:0] IDX_ROUTE_MASK = 8'h05;
	localparam logic [7:0] IDX_GLOBAL     = 8'h1e;
	localparam logic [7:0] IDX_DIAG       = 8'h20;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int BIT_DETECT     = 3;
	localparam int BIT_READY      = 2;
	localparam int BIT_BAT_LOW    = 1;
	localparam int BIT_BAT_DEAD   = 0;
	localparam int BIT_RING_EN    = 7;
	localparam int BIT_CARD_KIND  = 5;
	localparam int BIT_PCI_ROUTE  = 4;
	localparam int BIT_CLEAR_MODE = 2;
	localparam int BIT_DIAG_EVENT = 5;
	localparam int ROUTE_LSB      = 4;
	localparam int ROUTE_W        = 4;
	localparam int FLAG_W         = 4;

	// ==========================================================
	// reset values and encodings
	// ==========================================================
	localparam logic [7:0]         RST_STATUS     = 8'h00;
	localparam logic [7:0]         RST_GEN_CTRL   = 8'h00;
	localparam logic [7:0]         RST_ROUTE_MASK = 8'h00;
	localparam logic [7:0]         RST_GLOBAL     = 8'h00;
	localparam logic [7:0]         RST_DIAG       = 8'h00;
	localparam logic [ROUTE_W-1:0] ROUTE_NONE     = 4'h0;
	localparam logic [ROUTE_W-1:0] ROUTE_SMI      = 4'h2;
	localparam logic [31:0]        RD_ZERO        = 32'h0000_0000;

	// cycles the pin synchronisers need before their output means anything
	localparam logic [1:0] SYNC_FILL = 2'h3;

	// ==========================================================
	// socket pins, all levels as seen at the connector
	// ==========================================================
	typedef struct packed {
		logic detect_pin_one;
		logic detect_pin_two;
		logic card_ready;
		logic battery_or_ring_line_n;
		logic battery_warn_line_n;
	} cse_pins_s;

	localparam int PIN_W = $bits(cse_pins_s);

	// byte address of a register index
	function automatic logic [9:0] reg_addr(input logic [7:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction

endpackage

// >>> bench/cse_event_ctrl_asserts.sv
// checker for the event controller, watching its ports only.
// assumes byte addresses 0x0c ctrl, 0x10 status, 0x14 route/mask, 0x80 diag.
`timescale 1ns/1ps
module cse_chk
	import cse_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int IRQ_N  = 16
) (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	// socket and interrupts
	input wire cse_pins_s         socket_pins,
	input wire logic [IRQ_N-1:0]  legacy_irq,
	input wire logic              smi_request,
	input wire logic              pci_int_request
);
	// ====
	// shadow of the routing registers
	logic [7:0] ctrl_q;
	logic [7:0] mask_q;
	logic       diag_q;
	wire take = psel && penable && pready && !pslverr;
	wire st_rd = take && !pwrite && paddr == ADDR_W'(12'h010);
	wire [3:0] code = mask_q[7:4];
	wire pci_ok = ctrl_q[BIT_PCI_ROUTE] || (code == ROUTE_NONE && diag_q);
	wire smi_ok = !pci_ok && code == ROUTE_SMI;
	wire [IRQ_N-1:0] leg_ok = (pci_ok || smi_ok || code == ROUTE_NONE) ? '0 : IRQ_N'(1) << code;
	wire any_out = |legacy_irq || smi_request || pci_int_request;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 8'h00;
			mask_q <= 8'h00;
			diag_q <= 1'b0;
		end else if (take && pwrite && pstrb[0]) begin
			if (paddr == ADDR_W'(12'h00c)) ctrl_q <= pwdata[7:0];
			if (paddr == ADDR_W'(12'h014)) mask_q <= pwdata[7:0];
			if (paddr == ADDR_W'(12'h080)) diag_q <= pwdata[BIT_DIAG_EVENT];
		end
	end
	// ====
	// assertions
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_reset_quiet: assert property ($rose(presetn) |-> !any_out)
		else $error("output after reset");
	a_status_top_zero: assert property (st_rd |-> prdata[31:4] == 28'h0)
		else $error("status top bits");
	a_masked_reads_zero: assert property (st_rd |-> (prdata[3:0] & ~mask_q[3:0]) == 4'h0)
		else $error("masked bit read");
	a_io_kind_zero: assert property (st_rd && ctrl_q[BIT_CARD_KIND] |-> prdata[2:1] == 2'h0)
		else $error("io card bits");
	a_legacy_route: assert property ((legacy_irq & ~(leg_ok | $past(leg_ok))) == '0)
		else $error("legacy route");
	a_smi_route: assert property (smi_request |-> smi_ok || $past(smi_ok))
		else $error("smi route");
	a_pci_route: assert property (pci_int_request |-> pci_ok || $past(pci_ok))
		else $error("pci route");
	a_irq_needs_mask: assert property (any_out |-> |mask_q[3:0] || $past(|mask_q[3:0]))
		else $error("irq without mask");
	a_answer_pulse: assert property (pready |-> $past(psel && penable) ##1 !pready)
		else $error("answer timing");
	cover property (smi_request);
	cover property (pci_int_request);
	cover property (st_rd && prdata[3:0] != 4'h0);
endmodule // cse_chk

bind cse_event_ctrl cse_chk #(.ADDR_W(ADDR_W), .IRQ_N(IRQ_N)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.socket_pins(socket_pins), .legacy_irq(legacy_irq), .smi_request(smi_request),
	.pci_int_request(pci_int_request));

// >>> bench/cse_card_model.sv
// card in the socket, turning bench levels into socket pins.
// assumes every socket line has a pull-up while the socket is empty.
`timescale 1ns/1ps
module cse_card_model
	import cse_pkg::*;
#(
	parameter int LAG = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// card state
	input wire logic card_in,
	input wire logic busy,
	input wire logic warn,
	input wire logic dead,
	// socket
	output wire cse_pins_s pins
);
	// second contact meets late, so one insertion gives two pin changes
	logic [LAG-1:0] lag_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lag_q <= '0;
		else lag_q <= {lag_q[LAG-2:0], card_in};
	end
	assign pins.detect_pin_one = !card_in;
	assign pins.detect_pin_two = !lag_q[LAG-1];
	assign pins.card_ready = !(card_in && busy);
	assign pins.battery_or_ring_line_n = !(card_in && dead);
	assign pins.battery_warn_line_n = !(card_in && warn);
endmodule // cse_card_model

// >>> bench/test_card_status_change_irq.sv
// bench for the event controller with a card model on the socket.
// assumes the checker binds itself to the controller.
`timescale 1ns/1ps
module test_card_status_change_irq
	import cse_pkg::*;
;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mask;
		logic [1:0] ev;
		logic [7:0] stat;
	} cse_row_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, smi, pci, e;
	logic        card_in, busy, warn, dead;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, want;
	logic [15:0] legacy;
	cse_pins_s   pins;
	int          fail_count, n_tests;
	wire  [31:0] outs = {14'h0, pci, smi, legacy};
	logic [11:0] regs [5] = '{12'h00c, 12'h010, 12'h014, 12'h078, 12'h080};
	cse_row_s    rows [10] = '{'{8'h00, 8'h38, 2'd0, 8'h08}, '{8'h00, 8'h24, 2'd1, 8'h04},
		'{8'h10, 8'hf2, 2'd2, 8'h02}, '{8'h00, 8'hf1, 2'd3, 8'h01},
		'{8'h20, 8'h16, 2'd1, 8'h00}, '{8'h20, 8'h16, 2'd2, 8'h00},
		'{8'h20, 8'h11, 2'd3, 8'h01}, '{8'h80, 8'h91, 2'd3, 8'h01},
		'{8'h00, 8'h07, 2'd0, 8'h00}, '{8'h00, 8'h08, 2'd0, 8'h08}};

	cse_event_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .socket_pins(pins), .legacy_irq(legacy),
		.smi_request(smi), .pci_int_request(pci));
	cse_card_model card (.pclk(pclk), .presetn(presetn), .card_in(card_in), .busy(busy),
		.warn(warn), .dead(dead), .pins(pins));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ====
	// tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			fail_count++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// pin event, then time for synchroniser, flag and output to settle
	task automatic kick(input logic [1:0] ev);
		case (ev)
			2'd0: card_in <= ~card_in;
			2'd1: busy <= 1'b1;
			2'd2: warn <= 1'b1;
			default: dead <= 1'b1;
		endcase
		repeat (8) @(posedge pclk);
		{busy, warn, dead} <= 3'b000;
		repeat (10) @(posedge pclk);
	endtask
	function automatic logic [31:0] exp_out(input logic [7:0] ctrl, input logic [7:0] mask,
		input logic diag, input logic pend);
		logic [3:0] c;
		c = mask[7:4];
		exp_out = 32'h0;
		if (pend && (ctrl[4] || (c == 4'h0 && diag))) exp_out[17] = 1'b1;
		else if (pend && c == 4'h2) exp_out[16] = 1'b1;
		else if (pend && c != 4'h0) exp_out[c] = 1'b1;
	endfunction
	// ====
	// sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, card_in, busy, warn, dead} = '0;
		{fail_count, n_tests} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b1, 12'h00c, rows[i].ctrl);
			apb(1'b1, 12'h014, rows[i].mask);
			kick(rows[i].ev);
			want = exp_out(rows[i].ctrl, rows[i].mask, 1'b0, rows[i].stat != 0);
			chk("irq", want, outs);
			apb(1'b0, 12'h010, 8'h00);
			chk("status", {24'h0, rows[i].stat}, r);
			apb(1'b0, 12'h010, 8'h00);
			chk("read clear", 32'h0, r);
			repeat (3) @(posedge pclk);
			chk("irq off", 32'h0, outs);
			$display("row %0d done", i);
		end
		kick(2'd0);
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, 12'h014, {c[3:0], 4'h8});
			repeat (3) @(posedge pclk);
			chk("route", exp_out(8'h00, {c[3:0], 4'h8}, 1'b0, 1'b1), outs);
		end
		apb(1'b1, 12'h080, 8'h20);
		apb(1'b1, 12'h014, 8'h08);
		repeat (3) @(posedge pclk);
		chk("diag route", exp_out(8'h00, 8'h08, 1'b1, 1'b1), outs);
		apb(1'b1, 12'h080, 8'h00);
		apb(1'b0, 12'h010, 8'h00);
		$display("route sweep done");
		apb(1'b1, 12'h078, 8'h04);
		kick(2'd0);
		apb(1'b0, 12'h010, 8'h00);
		apb(1'b0, 12'h010, 8'h00);
		chk("w1c hold", 32'h8, r);
		apb(1'b1, 12'h010, 8'h08);
		apb(1'b0, 12'h010, 8'h00);
		chk("w1c clear", 32'h0, r);
		apb(1'b1, 12'h078, 8'h00);
		apb(1'b0, 12'h040, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		$display("clear modes done");
		kick(2'd0);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[k]) begin
			apb(1'b0, regs[k], 8'h00);
			chk("reset value", 32'h0, r);
		end
		chk("reset irq", 32'h0, outs);
		$display("reset done");
		final_report();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		final_report();
	end
endmodule // test_card_status_change_irq
